/* hdl/runtime_settings_decoder.sv */
// Run-time settings command decoder with an AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Report byte 0 holding 0x60 marks a run-time settings command whose later bytes are decoded.
// - Decoded settings live only in volatile flops and return to defaults at every reset.
// - After a command the reply holds the code echoed in byte 0 and in byte 1 status zero for 0x60, one for any other code.
// - Byte 5 bit 7 set applies the reference selection, cleared leaves it alone.
// - Byte 5 bits 2-1 choose the reference module output: 4.096V, 2.048V, 1.024V or off.
// - Byte 5 bit 0 picks the internal reference module when one, the supply when zero.
// - Byte 6 bit 7 must be set for any edge setting or the flag to change.
// - Byte 6 bit 4 lets bit 3 load the rising-edge trigger enable.
// - Byte 6 bit 2 lets bit 1 load the falling-edge trigger enable.
// - Byte 6 bit 0 set clears the latched detection flag, zero leaves it.
// - Byte 7 equal to one loads the pin settings byte, zero keeps the present pin setup.
// - Byte 8 bit 4 is the level driven on the first general pin when it is an output.
// - Byte 8 bit 3 sets that pin's direction, one input and zero output, for plain I/O only.
// - Byte 8 bits 2-0 designate plain I/O, suspend indicator or receive activity LED.
module runtime_settings_decoder (
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic int_sense,
   input wire logic suspend_indicator,
   input wire logic rx_activity,
   input wire logic first_general_pin_in,
   output logic first_general_pin_out,
   output logic first_general_pin_oe,
   output var runtime_settings_pkg::adc_ref_s adc_ref,
   output logic int_flag
);
   typedef struct packed {
      logic [runtime_settings_pkg::CMD_WORDS-1:0][31:0] cmd;
      runtime_settings_pkg::exec_state_e st;
      runtime_settings_pkg::adc_ref_s adc;
      runtime_settings_pkg::edge_cfg_s edge_cfg;
      runtime_settings_pkg::pin_cfg_s pin;
      logic clr;
      logic [7:0] resp_code;
      logic [7:0] resp_status;
      logic ph_valid;
      logic ph_write;
      logic [7:0] ph_addr;
      logic rd_wait;
      logic [31:0] rdata;
   } dec_state_s;

   dec_state_s s_r, s_nxt;
   logic addr_take;
   logic exec;
   logic set_cmd;
   logic [7:0] b0;
   logic [7:0] b5;
   logic [7:0] b6;
   logic [7:0] b7;
   logic [7:0] b8;
   logic func_legal;
   logic [31:0] rd_mux;

   // Report bytes as seen by the decoder
   assign b0 = runtime_settings_pkg::cmd_byte(s_r.cmd, runtime_settings_pkg::BYTE_CODE);
   assign b5 = runtime_settings_pkg::cmd_byte(s_r.cmd, runtime_settings_pkg::BYTE_ADC_REF);
   assign b6 = runtime_settings_pkg::cmd_byte(s_r.cmd, runtime_settings_pkg::BYTE_EDGE);
   assign b7 = runtime_settings_pkg::cmd_byte(s_r.cmd, runtime_settings_pkg::BYTE_PIN_LOAD);
   assign b8 = runtime_settings_pkg::cmd_byte(s_r.cmd, runtime_settings_pkg::BYTE_PIN0);
   assign exec = (s_r.st == runtime_settings_pkg::ST_EXEC);
   assign set_cmd = exec && (b0 == runtime_settings_pkg::CMD_SET_RUNTIME);
   // Codes 011-111 are don't care and must not disturb the designation
   assign func_legal = (b8[runtime_settings_pkg::BIT_FUNC_HI:runtime_settings_pkg::BIT_FUNC_LO]
                        <= runtime_settings_pkg::FUNC_RX_LED);

   // Address phase is taken only on an active transfer with the bus ready
   assign addr_take = hsel & htrans[runtime_settings_pkg::HTRANS_ACTIVE] & hready;

   // Reads take one wait state so a write just ahead of them is always seen;
   // writes stall only for the single execute cycle, which reads the buffer
   assign hreadyout = ~(s_r.ph_valid & ((~s_r.ph_write & s_r.rd_wait)
                        | (s_r.ph_write & exec)));
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;
   assign adc_ref = s_r.adc;

   // Read data selection; unmapped offsets read as zero
   always_comb begin
      unique case (s_r.ph_addr)
         runtime_settings_pkg::OFF_CMD0: rd_mux = s_r.cmd[0];
         runtime_settings_pkg::OFF_CMD1: rd_mux = s_r.cmd[1];
         runtime_settings_pkg::OFF_CMD2: rd_mux = s_r.cmd[2];
         runtime_settings_pkg::OFF_RESP: rd_mux = {16'h0000, s_r.resp_status, s_r.resp_code};
         runtime_settings_pkg::OFF_STATE: begin
            rd_mux = {{runtime_settings_pkg::STATE_PAD{1'b0}}, exec, first_general_pin_in,
                      int_flag, s_r.pin, s_r.edge_cfg, s_r.adc};
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus slave, command buffer and decoder next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.clr = 1'b0;
      // Bus phase tracking
      if (hreadyout) begin
         s_nxt.ph_valid = addr_take;
         s_nxt.ph_write = hwrite;
         s_nxt.ph_addr = haddr[7:0];
         s_nxt.rd_wait = addr_take & ~hwrite;
      end else begin
         s_nxt.rd_wait = 1'b0;
         s_nxt.rdata = rd_mux;
      end
      // Write data phase lands here
      if (s_r.ph_valid && s_r.ph_write && hreadyout) begin
         unique case (s_r.ph_addr)
            runtime_settings_pkg::OFF_CMD0: s_nxt.cmd[0] = hwdata;
            runtime_settings_pkg::OFF_CMD1: s_nxt.cmd[1] = hwdata;
            runtime_settings_pkg::OFF_CMD2: s_nxt.cmd[2] = hwdata;
            runtime_settings_pkg::OFF_GO: s_nxt.st = runtime_settings_pkg::ST_EXEC;
            default: s_nxt.st = s_r.st;
         endcase
      end
      // Execute: decode the report once and post the reply
      unique case (s_r.st)
         runtime_settings_pkg::ST_IDLE: begin
            s_nxt.resp_code = s_r.resp_code;
         end
         runtime_settings_pkg::ST_EXEC: begin
            s_nxt.st = runtime_settings_pkg::ST_IDLE;
            s_nxt.resp_code = b0;
            s_nxt.resp_status = set_cmd ? runtime_settings_pkg::STATUS_OK
                                        : runtime_settings_pkg::STATUS_UNKNOWN;
            if (set_cmd) begin
               // Reference selection, only under its own load bit
               if (b5[runtime_settings_pkg::BIT_LOAD]) begin
                  s_nxt.adc.mod_sel =
                     b5[runtime_settings_pkg::BIT_REF_HI:runtime_settings_pkg::BIT_REF_LO];
                  s_nxt.adc.ref_src = b5[runtime_settings_pkg::BIT_REF_SRC];
               end
               // Edge detection setup and flag clear, gated by the master enable
               if (b6[runtime_settings_pkg::BIT_LOAD]) begin
                  if (b6[runtime_settings_pkg::BIT_RISE_EN]) begin
                     s_nxt.edge_cfg.rise_en = b6[runtime_settings_pkg::BIT_RISE_VAL];
                  end
                  if (b6[runtime_settings_pkg::BIT_FALL_EN]) begin
                     s_nxt.edge_cfg.fall_en = b6[runtime_settings_pkg::BIT_FALL_VAL];
                  end
                  s_nxt.clr = b6[runtime_settings_pkg::BIT_FLAG_CLR];
               end
               // Pin setup; any byte 7 value but one leaves the pin as it is
               if (b7 == runtime_settings_pkg::PIN_LOAD_YES) begin
                  s_nxt.pin.val = b8[runtime_settings_pkg::BIT_PIN_VAL];
                  s_nxt.pin.dir = b8[runtime_settings_pkg::BIT_PIN_DIR];
                  if (func_legal) begin
                     s_nxt.pin.func =
                        b8[runtime_settings_pkg::BIT_FUNC_HI:runtime_settings_pkg::BIT_FUNC_LO];
                  end
               end
            end
         end
      endcase
   end

   // All settings are volatile and fall back to defaults on reset
   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
         s_r.st <= runtime_settings_pkg::ST_IDLE;
         s_r.adc <= runtime_settings_pkg::ADC_REF_RESET;
         s_r.edge_cfg <= runtime_settings_pkg::EDGE_CFG_RESET;
         s_r.pin <= runtime_settings_pkg::PIN_CFG_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Flag clear reaches the detector the cycle after execute
   edge_flag u_edge (
      .clk(clk),
      .reset(reset),
      .sense(int_sense),
      .cfg(s_r.edge_cfg),
      .clear(s_r.clr),
      .flag(int_flag)
   );

   // First general pin driver
   pin_mux u_pin (
      .clk(clk),
      .reset(reset),
      .cfg(s_r.pin),
      .suspend_indicator(suspend_indicator),
      .rx_activity(rx_activity),
      .pin_out(first_general_pin_out),
      .pin_oe(first_general_pin_oe)
   );

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   a_reply_echo: assert property (
      exec |=> s_r.resp_code == $past(b0) && s_r.resp_status ==
         (($past(b0) == runtime_settings_pkg::CMD_SET_RUNTIME) ?
          runtime_settings_pkg::STATUS_OK : runtime_settings_pkg::STATUS_UNKNOWN))
      else $error("reply wrong");
   a_other_code: assert property (
      exec && b0 != runtime_settings_pkg::CMD_SET_RUNTIME |=> $stable(s_r.adc)
         && $stable(s_r.pin) && $stable(s_r.edge_cfg)) else $error("foreign code applied");
   a_ref_apply: assert property (
      set_cmd && b5[runtime_settings_pkg::BIT_LOAD] |=> adc_ref.mod_sel == $past(b5[2:1])
         && adc_ref.ref_src == $past(b5[0])) else $error("reference not loaded");
   a_ref_hold: assert property (
      set_cmd && !b5[runtime_settings_pkg::BIT_LOAD] |=> $stable(adc_ref))
      else $error("reference changed");
   a_edge_hold: assert property (
      set_cmd && !b6[runtime_settings_pkg::BIT_LOAD] |=> $stable(s_r.edge_cfg) && !s_r.clr)
      else $error("edge setup changed");
   a_rise_load: assert property (
      set_cmd && b6[7] && b6[4] |=> s_r.edge_cfg.rise_en == $past(b6[3]))
      else $error("rising enable wrong");
   a_fall_load: assert property (
      set_cmd && b6[7] && b6[2] |=> s_r.edge_cfg.fall_en == $past(b6[1]))
      else $error("falling enable wrong");
   a_clear_pulse: assert property (
      set_cmd && b6[7] && b6[0] |=> s_r.clr ##1 !s_r.clr) else $error("clear pulse wrong");
   a_pin_hold: assert property (
      set_cmd && b7 != runtime_settings_pkg::PIN_LOAD_YES |=> $stable(s_r.pin))
      else $error("pin changed");
   a_pin_load: assert property (
      set_cmd && b7 == runtime_settings_pkg::PIN_LOAD_YES && func_legal
      |=> s_r.pin.func == $past(b8[2:0]) && s_r.pin.dir == $past(b8[3])
         && s_r.pin.val == $past(b8[4])) else $error("pin not loaded");
   a_func_ignore: assert property (
      set_cmd && !func_legal |=> $stable(s_r.pin.func)) else $error("dont care applied");
   a_reset_defaults: assert property (disable iff (1'b0)
      reset |=> adc_ref == runtime_settings_pkg::ADC_REF_RESET
         && s_r.pin == runtime_settings_pkg::PIN_CFG_RESET) else $error("defaults lost");
   a_read_wait: assert property (
      addr_take && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
      else $error("read wait wrong");

   c_ref_load: cover property (set_cmd && b5[7]);
   c_pin_load: cover property (set_cmd && b7 == runtime_settings_pkg::PIN_LOAD_YES);
   c_flag_clear: cover property (int_flag ##1 s_r.clr ##1 !int_flag);
endmodule
`default_nettype wire

/* hdl/runtime_settings_pkg.sv */
// Constants, field layouts and carrier types for the run-time settings decoder
package runtime_settings_pkg;
   // Command codes and reply status
   localparam logic [7:0] CMD_SET_RUNTIME = 8'h60;
   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] STATUS_UNKNOWN = 8'h01;
   // Register byte offsets on the bus
   localparam logic [7:0] OFF_CMD0 = 8'h00;
   localparam logic [7:0] OFF_CMD1 = 8'h04;
   localparam logic [7:0] OFF_CMD2 = 8'h08;
   localparam logic [7:0] OFF_GO = 8'h0c;
   localparam logic [7:0] OFF_RESP = 8'h10;
   localparam logic [7:0] OFF_STATE = 8'h14;
   localparam int CMD_WORDS = 3;
   localparam int HTRANS_ACTIVE = 1;
   localparam int STATE_PAD = 19;
   // Byte positions inside the command report
   localparam int BYTE_CODE = 0;
   localparam int BYTE_ADC_REF = 5;
   localparam int BYTE_EDGE = 6;
   localparam int BYTE_PIN_LOAD = 7;
   localparam int BYTE_PIN0 = 8;
   // Bit positions inside those bytes
   localparam int BIT_LOAD = 7;
   localparam int BIT_REF_HI = 2;
   localparam int BIT_REF_LO = 1;
   localparam int BIT_REF_SRC = 0;
   localparam int BIT_RISE_EN = 4;
   localparam int BIT_RISE_VAL = 3;
   localparam int BIT_FALL_EN = 2;
   localparam int BIT_FALL_VAL = 1;
   localparam int BIT_FLAG_CLR = 0;
   localparam int BIT_PIN_VAL = 4;
   localparam int BIT_PIN_DIR = 3;
   localparam int BIT_FUNC_HI = 2;
   localparam int BIT_FUNC_LO = 0;
   localparam logic [7:0] PIN_LOAD_YES = 8'h01;
   // Reference module output: 11 4.096V, 10 2.048V, 01 1.024V, 00 off
   localparam logic [1:0] REF_MOD_OFF = 2'h0;
   localparam logic [2:0] FUNC_GPIO = 3'h0;
   localparam logic [2:0] FUNC_SUSPEND = 3'h1;
   localparam logic [2:0] FUNC_RX_LED = 3'h2;
   typedef struct packed {logic [1:0] mod_sel; logic ref_src;} adc_ref_s;
   typedef struct packed {logic rise_en; logic fall_en;} edge_cfg_s;
   typedef struct packed {logic [2:0] func; logic dir; logic val;} pin_cfg_s;
   localparam adc_ref_s ADC_REF_RESET = '{mod_sel: REF_MOD_OFF, ref_src: 1'b0};
   localparam edge_cfg_s EDGE_CFG_RESET = '{rise_en: 1'b0, fall_en: 1'b0};
   localparam pin_cfg_s PIN_CFG_RESET = '{func: FUNC_GPIO, dir: 1'b1, val: 1'b0};
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC} exec_state_e;
   // Picks one report byte out of the little-endian command words
   function automatic logic [7:0] cmd_byte(input logic [CMD_WORDS-1:0][31:0] words,
                                           input int idx);
      return words[idx / 4][(idx % 4) * 8 +: 8];
   endfunction
endpackage

/* hdl/edge_flag.sv */
// Edge detector with a latched interrupt detection flag
`timescale 1ns/1ns
`default_nettype none
module edge_flag (
   input wire logic clk,
   input wire logic reset,
   input wire logic sense,
   input wire runtime_settings_pkg::edge_cfg_s cfg,
   input wire logic clear,
   output logic flag
);
   typedef struct packed {logic primed; logic prev; logic flag;} edge_state_s;
   edge_state_s s_r, s_nxt;
   logic set_ev;

   // First sample after reset only primes, so a high input is no false rise
   always_comb begin
      set_ev = s_r.primed & ((cfg.rise_en & sense & ~s_r.prev)
               | (cfg.fall_en & ~sense & s_r.prev));
      s_nxt = s_r;
      s_nxt.primed = 1'b1;
      s_nxt.prev = sense;
      s_nxt.flag = set_ev | (s_r.flag & ~clear);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign flag = s_r.flag;

   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_set_wins: assert property (set_ev |=> flag) else $error("edge lost");
   a_flag_clear: assert property (clear && !set_ev |=> !flag) else $error("flag not cleared");
endmodule
`default_nettype wire

/* hdl/pin_mux.sv */
// Output driver of the first general pin, by its designated function
`timescale 1ns/1ns
`default_nettype none
module pin_mux (
   input wire logic clk,
   input wire logic reset,
   input wire runtime_settings_pkg::pin_cfg_s cfg,
   input wire logic suspend_indicator,
   input wire logic rx_activity,
   output logic pin_out,
   output logic pin_oe
);
   typedef struct packed {logic out; logic oe;} pin_state_s;
   pin_state_s s_r, s_nxt;

   // Direction only matters for plain I/O; alternate functions always drive
   always_comb begin
      s_nxt = '0;
      unique case (cfg.func)
         runtime_settings_pkg::FUNC_GPIO: begin
            s_nxt.oe = ~cfg.dir;
            s_nxt.out = cfg.val;
         end
         runtime_settings_pkg::FUNC_SUSPEND: begin
            s_nxt.oe = 1'b1;
            s_nxt.out = suspend_indicator;
         end
         runtime_settings_pkg::FUNC_RX_LED: begin
            s_nxt.oe = 1'b1;
            s_nxt.out = rx_activity;
         end
         default: s_nxt = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pin_out = s_r.out;
   assign pin_oe = s_r.oe;

   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_gpio_level: assert property (cfg.func == runtime_settings_pkg::FUNC_GPIO && !cfg.dir
      |=> pin_oe && pin_out == $past(cfg.val)) else $error("gpio level wrong");
   a_gpio_input: assert property (cfg.func == runtime_settings_pkg::FUNC_GPIO && cfg.dir
      |=> !pin_oe) else $error("input pin driven");
   a_suspend_out: assert property (cfg.func == runtime_settings_pkg::FUNC_SUSPEND
      |=> pin_oe && pin_out == $past(suspend_indicator)) else $error("suspend wrong");
endmodule
`default_nettype wire

/* sim/settings_host.sv */
// Host-side bus master that writes settings command reports into the decoder
`timescale 1ns/1ns
`default_nettype none
module settings_host (
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   logic [31:0] rd_seen;

   // Bus idle at time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // Samples hready before each edge, so the sample never races the edge itself
   task automatic wait_ready(output bit ok);
      bit r;
      ok = 1'b0;
      for (int i = 0; i < 64; i++) begin
         @(negedge clk);
         r = (hready === 1'b1);
         rd_seen = hrdata;
         @(posedge clk);
         if (r) begin
            ok = 1'b1;
            break;
         end
      end
   endtask

   // One single word transfer; entered just after a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output bit ok);
      bit ok1;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready(ok1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      if (wr) hwdata <= d;
      wait_ready(ok);
      q = rd_seen;
      // Released data lines must not keep showing the last word
      if (wr) hwdata <= ~d;
      ok = ok & ok1;
   endtask

   // One command report; bytes other than 0 and 5..8 carry random filler
   task automatic send_cmd(input logic [7:0] code, input logic [7:0] b5, input logic [7:0] b6,
                           input logic [7:0] b7, input logic [7:0] b8,
                           output logic [15:0] resp, output bit ok);
      logic [31:0] q;
      bit k0, k1, k2, k3, k4;
      xfer(1'b1, runtime_settings_pkg::OFF_CMD0, {24'($urandom()), code}, q, k0);
      xfer(1'b1, runtime_settings_pkg::OFF_CMD1, {b7, b6, b5, 8'($urandom())}, q, k1);
      xfer(1'b1, runtime_settings_pkg::OFF_CMD2, {24'($urandom()), b8}, q, k2);
      xfer(1'b1, runtime_settings_pkg::OFF_GO, 32'h1, q, k3);
      xfer(1'b0, runtime_settings_pkg::OFF_RESP, 32'h0, q, k4);
      resp = q[15:0];
      ok = k0 & k1 & k2 & k3 & k4;
   endtask
endmodule
`default_nettype wire

/* sim/runtime_settings_decoder_tb_top.sv */
// Self-checking bench for the run-time settings decoder
`timescale 1ns/1ns
`default_nettype none
module runtime_settings_decoder_tb_top;
   logic clk, reset, hsel, hwrite, hreadyout, hresp, int_sense, int_flag;
   logic suspend_indicator, rx_activity, pin_ext, pin_in, pin_out, pin_oe;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] last_resp;
   runtime_settings_pkg::adc_ref_s adc_ref, e_adc;
   runtime_settings_pkg::pin_cfg_s e_pin;
   logic e_rise, e_fall, e_flag;
   logic [31:0] exp_q[$];
   logic [31:0] obs, exp_w;
   event sample_ev;
   int err_count = 0;
   int tests_run = 0;

   // Pin wire: our end drives it, otherwise the outside level shows
   assign pin_in = pin_oe ? pin_out : pin_ext;

   runtime_settings_decoder i_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .int_sense(int_sense),
      .suspend_indicator(suspend_indicator), .rx_activity(rx_activity),
      .first_general_pin_in(pin_in), .first_general_pin_out(pin_out),
      .first_general_pin_oe(pin_oe), .adc_ref(adc_ref), .int_flag(int_flag));

   settings_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   always #10 clk = ~clk;

   task automatic results();
      $display("checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Checker: port snapshot against the oldest note the driver left
   initial forever begin
      @(sample_ev);
      obs = {7'h0, hresp, last_resp, 2'h0, adc_ref, int_flag, pin_oe, pin_out & pin_oe};
      exp_w = exp_q.pop_front();
      tests_run++;
      if (obs !== exp_w) begin
         err_count++;
         $display("[ERR] %0t ns: saw %h, wanted %h", $time, obs, exp_w);
      end
   end

   // Notes the expected snapshot; output level only matters while driving
   task automatic note(input logic [15:0] seen, input logic [15:0] want);
      logic oe, o;
      @(negedge clk);
      oe = (e_pin.func == runtime_settings_pkg::FUNC_GPIO) ? ~e_pin.dir : 1'b1;
      o = (e_pin.func == runtime_settings_pkg::FUNC_GPIO) ? e_pin.val :
          (e_pin.func == runtime_settings_pkg::FUNC_SUSPEND) ? suspend_indicator : rx_activity;
      last_resp = seen;
      exp_q.push_back({8'h0, want, 2'h0, e_adc, e_flag, oe, o & oe});
      -> sample_ev;
      @(posedge clk);
   endtask

   task automatic do_cmd(input logic [7:0] code, input logic [7:0] b5, input logic [7:0] b6,
                         input logic [7:0] b7, input logic [7:0] b8);
      logic [15:0] r, want;
      bit ok;
      host.send_cmd(code, b5, b6, b7, b8, r, ok);
      if (!ok) begin
         err_count++;
         results();
      end
      want = {runtime_settings_pkg::STATUS_UNKNOWN, code};
      if (code == runtime_settings_pkg::CMD_SET_RUNTIME) begin
         want = {runtime_settings_pkg::STATUS_OK, code};
         if (b5[7]) e_adc = {b5[2:1], b5[0]};
         if (b6[7] && b6[4]) e_rise = b6[3];
         if (b6[7] && b6[2]) e_fall = b6[1];
         if (b6[7] && b6[0]) e_flag = 1'b0;
         if (b7 == runtime_settings_pkg::PIN_LOAD_YES) begin
            if (b8[2:0] <= 3'h2) e_pin.func = b8[2:0];
            e_pin.dir = b8[3];
            e_pin.val = b8[4];
         end
      end
      // Pin and flag updates trail the execute cycle by two edges
      repeat (3) @(posedge clk);
      note(r, want);
   endtask

   // Moves the watched level; the one-edge detector latency is covered by the wait
   task automatic sense(input logic v);
      int_sense <= v;
      if (v && !int_sense && e_rise) e_flag = 1'b1;
      if (!v && int_sense && e_fall) e_flag = 1'b1;
      repeat (4) @(posedge clk);
      note(16'h0, 16'h0);
   endtask

   task automatic model_reset();
      e_adc = runtime_settings_pkg::ADC_REF_RESET;
      e_pin = runtime_settings_pkg::PIN_CFG_RESET;
      e_rise = 1'b0;
      e_fall = 1'b0;
      e_flag = 1'b0;
   endtask

   initial begin
      logic [31:0] q;
      bit ok;
      clk = 1'b0;
      reset = 1'b1;
      int_sense = 1'b0;
      suspend_indicator = 1'b0;
      rx_activity = 1'b0;
      pin_ext = 1'b0;
      model_reset();
      void'($urandom(30662));
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      note(16'h0, 16'h0);
      $display("test reset defaults done");
      // Every reference code and source, filler in the don't-care bits
      for (int i = 0; i < 8; i++) begin
         do_cmd(8'h60, 8'h80 | (8'($urandom()) & 8'h78) | 8'(i), 8'h00, 8'h00, 8'h00);
      end
      do_cmd(8'h60, 8'($urandom()) & 8'h7f, 8'h00, 8'h00, 8'h00);
      $display("test adc reference done");
      do_cmd(8'h60, 8'h00, 8'h98 | (8'($urandom()) & 8'h60), 8'h00, 8'h00);
      sense(1'b1);
      do_cmd(8'h60, 8'h00, 8'h01, 8'h00, 8'h00);
      do_cmd(8'h60, 8'h00, 8'h81, 8'h00, 8'h00);
      do_cmd(8'h60, 8'h00, 8'h96, 8'h00, 8'h00);
      do_cmd(8'h60, 8'h00, 8'h8a, 8'h00, 8'h00);
      sense(1'b0);
      do_cmd(8'h60, 8'h00, 8'h80, 8'h00, 8'h00);
      do_cmd(8'h60, 8'h00, 8'h81, 8'h00, 8'h00);
      sense(1'b1);
      $display("test edge detection done");
      pin_ext <= 1'($urandom());
      for (int f = 0; f < 8; f++) begin
         suspend_indicator <= 1'($urandom());
         rx_activity <= 1'($urandom());
         do_cmd(8'h60, 8'h00, 8'h00, 8'h01, {3'($urandom()), 2'($urandom()), 3'(f)});
      end
      do_cmd(8'h60, 8'h00, 8'h00, 8'h01, 8'h10);
      do_cmd(8'h60, 8'h00, 8'h00, 8'h00, 8'h09);
      do_cmd(8'h60, 8'h00, 8'h00, 8'h02, 8'h0a);
      $display("test pin settings done");
      do_cmd(8'h61, 8'h87, 8'h81, 8'h01, 8'h09);
      host.xfer(1'b0, 8'h20, 32'h0, q, ok);
      if (!ok) begin
         err_count++;
         results();
      end
      note(q[15:0] | q[31:16], 16'h0);
      // Status word: settings as modelled, pin level as the wire shows it
      host.xfer(1'b0, runtime_settings_pkg::OFF_STATE, 32'h0, q, ok);
      if (!ok) begin
         err_count++;
         results();
      end
      note(q[15:0], {4'h0, ((e_pin.func == runtime_settings_pkg::FUNC_GPIO && !e_pin.dir) ?
         e_pin.val : pin_ext), e_flag, e_pin, e_rise, e_fall, e_adc});
      $display("test foreign code and unmapped read done");
      do_cmd(8'h60, 8'h87, 8'h9b, 8'h01, 8'h02);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      model_reset();
      repeat (2) @(posedge clk);
      note(16'h0, 16'h0);
      $display("test mid-run reset done");
      results();
   end
endmodule
`default_nettype wire
